/* usb_irq_pkg.sv */
package usb_irq_pkg;

    // ************************************************************
    // register map (byte addresses on the apb side)
    // ************************************************************
    localparam int          ADDR_W        = 8;
    localparam logic [7:0]  IE_OFS        = 8'h00;  // interrupt_source_enable
    localparam logic [7:0]  MODE_OFS      = 8'h04;  // global enable and selects
    localparam logic [7:0]  STAT_OFS      = 8'h08;  // sticky event status
    localparam logic [7:0]  CLR_OFS       = 8'h0C;  // write-one-to-clear

    // ************************************************************
    // enable register layout and reset values
    // ************************************************************
    localparam logic [31:0] IE_VALID      = 32'h03FF_FDFF; // 31:26, 9 reserved
    localparam logic [31:0] IE_RESET      = 32'h0000_0000;
    localparam logic [31:0] BRST_KEEP     = 32'h0000_0001; // survives bus reset
    localparam int          BRST_BIT      = 0;  // bus_reset_irq_en
    localparam int          SOF_BIT       = 1;  // frame_start_irq_en
    localparam int          PSOF_BIT      = 2;  // pseudo_frame_start_irq_en
    localparam int          SUSP_BIT      = 3;  // suspend_irq_en
    localparam int          RESM_BIT      = 4;  // resume_irq_en
    localparam int          HSCHG_BIT     = 5;  // highspeed_change_irq_en
    localparam int          DMA_BIT       = 6;  // dma_change_irq_en
    localparam int          SUPPLY_BIT    = 7;  // supply_sense_irq_en
    localparam int          SETUP_BIT     = 8;  // ctrl_setup_rx_irq_en
    localparam int          BUS_EV_W      = 9;  // bus event inputs 8:0
    localparam int          EP_BASE_BIT   = 10; // ep n rx at 10+2n, tx at 11+2n
    localparam int          EP_NUM_W      = 3;

    // ************************************************************
    // mode register: handshake selects and global enable
    // ************************************************************
    localparam int          SEL_ACK       = 0;  // select bit: ack raises event
    localparam int          SEL_NAK       = 1;  // select bit: nak raises event

    typedef struct packed {
        logic [1:0] out_ep_handshake_irq_select;
        logic [1:0] in_ep_handshake_irq_select;
        logic [1:0] control_ep_handshake_irq_select;
        logic       global_irq_en;
    } mode_t;

    localparam mode_t       MODE_RESET    = 7'h2A; // ack only, global off

    // one-hot enable bit of endpoint ep, tx side when tx is set
    function automatic logic [31:0] ep_event_bit(
        input logic [EP_NUM_W-1:0] ep,
        input logic                tx
    );
        ep_event_bit = 32'h0000_0001 << (EP_BASE_BIT + 2 * int'(ep) + int'(tx));
    endfunction

endpackage

/* hs_if.sv */
`timescale 1ns/1ps
// ************************************************************
// handshake path between register block and qualifier
// ************************************************************
interface hs_if;
    logic        valid;       // one handshake seen, one-cycle pulse
    logic        ack;         // 1 = ack, 0 = nak
    logic        tx;          // in transaction (transmit buffer)
    logic        setup;       // setup transaction on endpoint 0
    logic [2:0]  ep;          // endpoint number
    logic [6:0]  mode;        // packed mode_t from the register block
    logic [31:0] ep_events;   // qualified endpoint events, registered

    modport regs (output valid, ack, tx, setup, ep, mode, input ep_events);
    modport qual (input valid, ack, tx, setup, ep, mode, output ep_events);
endinterface // hs_if

/* hs_qualifier.sv */
`timescale 1ns/1ps
module hs_qualifier
    import usb_irq_pkg::*;
(
    input  wire logic pclk,
    input  wire logic presetn,
    hs_if.qual        h
);

    // ************************************************************
    // state
    // ************************************************************
    typedef struct packed {
        logic [31:0] ev;   // one-cycle endpoint event vector
    } qual_state_t;

    qual_state_t s_q;      // registered state
    qual_state_t s_d;      // next state
    mode_t       mode;     // decoded mode view
    logic [1:0]  sel;      // select that governs this handshake
    logic        hit;      // handshake passes its select

    assign mode = mode_t'(h.mode);

    // pick select, qualify, build one-hot event
    always_comb begin
        s_d = '0;
        if (h.ep == '0) begin
            sel = mode.control_ep_handshake_irq_select;
        end else if (h.tx) begin
            sel = mode.in_ep_handshake_irq_select;
        end else begin
            sel = mode.out_ep_handshake_irq_select;
        end
        hit = h.valid && (h.ack ? sel[SEL_ACK] : sel[SEL_NAK]);
        if (hit) begin
            // setup handshakes count as control out traffic
            s_d.ev = ep_event_bit(h.ep, h.tx && !h.setup);
        end
    end

    // register the event vector
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign h.ep_events = s_q.ev;

    // ************************************************************
    // checks
    // ************************************************************
    data_in_ack_a: assert property (@(posedge pclk) disable iff (!presetn)
        h.valid && h.ack && h.tx && h.ep != '0 && mode.in_ep_handshake_irq_select[SEL_ACK]
        |=> h.ep_events == ep_event_bit($past(h.ep), 1'b1))
        else $error("in ack did not raise its tx event");

    ctrl_blocked_a: assert property (@(posedge pclk) disable iff (!presetn)
        h.valid && h.ep == '0 && !h.ack && !mode.control_ep_handshake_irq_select[SEL_NAK]
        |=> h.ep_events == '0)
        else $error("control nak raised event while deselected");

    data_out_nak_a: assert property (@(posedge pclk) disable iff (!presetn)
        h.valid && !h.ack && !h.tx && h.ep != '0 && mode.out_ep_handshake_irq_select[SEL_NAK]
        |=> h.ep_events == ep_event_bit($past(h.ep), 1'b0))
        else $error("out nak did not raise its rx event");

endmodule // hs_qualifier

/* usb_interrupt_enable_mask.sv */
`timescale 1ns/1ps
// Contract
// - ack or nak handshakes raise endpoint events
// - in data handshakes use in select
// - out data handshakes use out select
// - endpoint 0 handshakes use control select
// - each bus event source enabled independently
// - bus reset clears enables except bus-reset
// - 32-bit enable, reset zero, reserved 31:26,9
// - data endpoint n: rx 10+2n, tx 11+2n
// - bit 11 control in, 10 control out
// - bit 8 enables setup received
// - bit 7 supply sense, 6 dma
// - bit 5 speed change, 4 resume
// - bit 3 suspend, 2 pseudo frame
// - bit 1 frame start, 0 bus reset
// - global enable low suppresses every interrupt
module usb_interrupt_enable_mask
    import usb_irq_pkg::*;
(
    input  wire logic                            pclk,
    input  wire logic                            presetn,
    input  wire logic                            psel,
    input  wire logic                            penable,
    input  wire logic                            pwrite,
    input  wire logic [usb_irq_pkg::ADDR_W-1:0]  paddr,
    input  wire logic [31:0]                     pwdata,
    output logic      [31:0]                     prdata,
    output logic                                 pready,
    output logic                                 pslverr,
    input  wire logic                            hs_valid,
    input  wire logic                            hs_ack,
    input  wire logic                            hs_tx,
    input  wire logic                            hs_setup,
    input  wire logic [usb_irq_pkg::EP_NUM_W-1:0] hs_ep,
    input  wire logic [usb_irq_pkg::BUS_EV_W-1:0] bus_events,
    output logic                                 irq
);

    import usb_irq_pkg::*;

    // ************************************************************
    // types and state
    // ************************************************************

    // apb slave phases
    typedef enum logic [0:0] {
        ST_IDLE   = 1'b0,   // waiting for a setup cycle
        ST_ACCESS = 1'b1    // answer presented, waiting for penable
    } apb_st_t;

    // every flop of the block but the qualifier's event register lives here
    typedef struct packed {
        apb_st_t     st;     // bus phase
        logic        rdy;    // pready
        logic        err;    // pslverr
        logic [31:0] rdata;  // prdata
        logic [31:0] ie;     // interrupt_source_enable
        logic [31:0] stat;   // sticky event flags
        mode_t       mode;   // global enable and handshake selects
        logic        irq;    // interrupt line
    } top_state_t;

    top_state_t  s_q;        // registered state
    top_state_t  s_d;        // next state

    // ************************************************************
    // handshake qualifier
    // ************************************************************

    // ep_events comes back registered, one edge behind the handshake
    hs_if hs ();             // link to the qualifier

    // the engine runs on pclk, so no synchroniser here
    assign hs.valid = hs_valid;
    assign hs.ack   = hs_ack;
    assign hs.tx    = hs_tx;
    assign hs.setup = hs_setup;
    assign hs.ep    = hs_ep;
    assign hs.mode  = s_q.mode;

    hs_qualifier u_qual (
        .pclk    (pclk),
        .presetn (presetn),
        .h       (hs)
    );

    // ************************************************************
    // event vector
    // ************************************************************

    logic [31:0] ev_all;     // every event of this cycle
    logic        bus_rst;    // usb bus reset seen

    // bus events land on their own enable positions
    always_comb begin
        ev_all = hs.ep_events;
        ev_all[SETUP_BIT]  = bus_events[SETUP_BIT];
        ev_all[SUPPLY_BIT] = bus_events[SUPPLY_BIT];
        ev_all[DMA_BIT]    = bus_events[DMA_BIT];
        ev_all[HSCHG_BIT]  = bus_events[HSCHG_BIT];
        ev_all[RESM_BIT]   = bus_events[RESM_BIT];
        ev_all[SUSP_BIT]   = bus_events[SUSP_BIT];
        ev_all[PSOF_BIT]   = bus_events[PSOF_BIT];
        ev_all[SOF_BIT]    = bus_events[SOF_BIT];
        ev_all[BRST_BIT]   = bus_events[BRST_BIT];
        // reserved positions never flag
        ev_all = ev_all & IE_VALID;
    end

    // a bus reset also flags, so firmware can see why enables vanished
    assign bus_rst = bus_events[BRST_BIT];

    // ************************************************************
    // apb decode
    // ************************************************************

    logic        setup_ph;   // setup cycle of a transfer
    logic        done;       // access completes at this edge
    logic        wr;         // write takes effect at this edge
    logic        mapped;     // address hits a register
    logic [31:0] rd_mux;     // read value for the setup address

    // the master holds address and data through the access phase,
    // so the write decode may look at them at the completing edge
    assign setup_ph = psel && !penable;
    assign done     = (s_q.st == ST_ACCESS) && psel && penable && s_q.rdy;
    assign wr       = done && pwrite;

    // read mux, unmapped and write-only read as zero
    always_comb begin
        mapped = 1'b1;
        rd_mux = '0;
        unique case (paddr)
            IE_OFS: begin
                rd_mux = s_q.ie & IE_VALID;
            end
            MODE_OFS: begin
                rd_mux = {25'h0, s_q.mode};
            end
            STAT_OFS: begin
                rd_mux = s_q.stat;
            end
            CLR_OFS: begin
                rd_mux = '0;
            end
            default: begin
                mapped = 1'b0;
            end
        endcase
    end

    // ************************************************************
    // next state
    // ************************************************************

    // one process carries bus, mask, flags and the line
    always_comb begin
        s_d = s_q;

        // bus phase: answer is ready one cycle after setup,
        // so every transfer has zero wait states
        unique case (s_q.st)
            ST_IDLE: begin
                if (setup_ph) begin
                    s_d.st    = ST_ACCESS;
                    s_d.rdy   = 1'b1;
                    s_d.err   = !mapped;
                    s_d.rdata = pwrite ? 32'h0000_0000 : rd_mux;
                end
            end
            ST_ACCESS: begin
                if (done) begin
                    s_d.st  = ST_IDLE;
                    s_d.rdy = 1'b0;
                    s_d.err = 1'b0;
                    // read data stands only with pready
                    s_d.rdata = 32'h0000_0000;
                end
            end
        endcase

        // software writes; status is read-only
        if (wr) begin
            unique case (paddr)
                IE_OFS: begin
                    // each source has its own bit
                    s_d.ie = pwdata & IE_VALID;
                end
                MODE_OFS: begin
                    s_d.mode = mode_t'(pwdata[6:0]);
                end
                default: begin
                end
            endcase
        end

        // a bus reset wins over a same-cycle write, so firmware
        // cannot re-arm a source the reset just dropped
        if (bus_rst) begin
            s_d.ie = s_d.ie & BRST_KEEP;
        end

        // sticky flags: a new event beats a same-cycle clear
        s_d.stat = s_q.stat;
        if (wr && paddr == CLR_OFS) begin
            s_d.stat = s_d.stat & ~pwdata;
        end
        s_d.stat = s_d.stat | ev_all;

        // one flop stage: irq trails the flag by a cycle, glitch free
        // line needs a flag, its enable and the global bit
        s_d.irq = s_q.mode.global_irq_en
                  && |(s_q.stat & s_q.ie);
    end

    // ************************************************************
    // registers
    // ************************************************************

    // hardware reset clears all enables
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q.st    <= ST_IDLE;
            s_q.rdy   <= 1'b0;
            s_q.err   <= 1'b0;
            s_q.rdata <= 32'h0000_0000;
            s_q.ie    <= IE_RESET;
            s_q.stat  <= 32'h0000_0000;
            s_q.mode  <= MODE_RESET;
            s_q.irq   <= 1'b0;
        end else begin
            s_q <= s_d;
        end
    end

    // mode comes up with ack-only selects and the global bit off
    // outputs straight from flops
    assign prdata  = s_q.rdata;
    assign pready  = s_q.rdy;
    assign pslverr = s_q.err;
    assign irq     = s_q.irq;

    // ************************************************************
    // checks
    // ************************************************************

    // write transfer in two steps
    sequence ie_wr_setup;
        psel && !penable && pwrite && paddr == IE_OFS;
    endsequence

    sequence ie_wr_access;
        psel && penable && pready && !bus_rst;
    endsequence

    sequence brst_hit;
        bus_rst && !(wr && paddr == IE_OFS);
    endsequence

    mask_reserved_a: assert property (@(posedge pclk) disable iff (!presetn)
        (s_q.ie & ~IE_VALID) == '0)
        else $error("reserved enable bit set");

    mask_write_a: assert property (@(posedge pclk) disable iff (!presetn)
        ie_wr_setup ##1 ie_wr_access
        |=> s_q.ie == ($past(pwdata) & IE_VALID))
        else $error("enable write not stored");

    brst_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
        brst_hit |=> (s_q.ie & ~BRST_KEEP) == '0
                     && s_q.ie[BRST_BIT] == $past(s_q.ie[BRST_BIT]))
        else $error("bus reset mask handling wrong");

    global_off_a: assert property (@(posedge pclk) disable iff (!presetn)
        !s_q.mode.global_irq_en |=> !irq)
        else $error("irq while global enable low");

    irq_cause_a: assert property (@(posedge pclk) disable iff (!presetn)
        irq |-> $past(s_q.mode.global_irq_en) && $past(|(s_q.stat & s_q.ie)))
        else $error("irq without enabled flag");

    irq_raise_a: assert property (@(posedge pclk) disable iff (!presetn)
        (ev_all & s_q.ie) != '0 && s_q.mode.global_irq_en && !bus_rst && !wr
        |=> ##1 irq)
        else $error("enabled event did not raise irq");

    flag_sticky_a: assert property (@(posedge pclk) disable iff (!presetn)
        ev_all != '0 |=> (s_q.stat & $past(ev_all)) == $past(ev_all))
        else $error("event flag lost");

    bus_answer_a: assert property (@(posedge pclk) disable iff (!presetn)
        s_q.st == ST_IDLE && psel && !penable |=> pready ##1 !pready)
        else $error("apb answer timing wrong");

    // ************************************************************
    // checks on the register answer and the flags
    // ************************************************************

    // read of the enable register, setup then answer
    sequence ie_rd_setup;
        s_q.st == ST_IDLE && psel && !penable && !pwrite && paddr == IE_OFS;
    endsequence

    sequence ie_rd_answer;
        pready && !pslverr && (prdata & ~IE_VALID) == '0;
    endsequence

    rd_reserved_a: assert property (@(posedge pclk) disable iff (!presetn)
        ie_rd_setup |=> ie_rd_answer)
        else $error("enable read shows reserved bits");

    // a clear write drops only flags with no new event
    clr_write_a: assert property (@(posedge pclk) disable iff (!presetn)
        wr && paddr == CLR_OFS
        |=> s_q.stat == (($past(s_q.stat) & ~$past(pwdata)) | $past(ev_all)))
        else $error("status clear handled wrong");

    // status has no write path of its own
    stat_ro_a: assert property (@(posedge pclk) disable iff (!presetn)
        wr && paddr == STAT_OFS |=> s_q.stat == ($past(s_q.stat) | $past(ev_all)))
        else $error("status changed by a write");

    // a bus reset touches the enables and its own status flag only
    mode_kept_a: assert property (@(posedge pclk) disable iff (!presetn)
        bus_rst && !(wr && paddr == MODE_OFS) |=> s_q.mode == $past(s_q.mode))
        else $error("bus reset changed the mode word");

    // an unmapped address answers with an error and no data
    unmapped_access_a: assert property (@(posedge pclk) disable iff (!presetn)
        s_q.st == ST_IDLE && setup_ph && !mapped |=> pslverr && prdata == '0)
        else $error("unmapped access not refused");

    // with global enable on, a set flag and its enable raise the line
    irq_level_a: assert property (@(posedge pclk) disable iff (!presetn)
        s_q.mode.global_irq_en && (s_q.stat & s_q.ie) != '0 |=> irq)
        else $error("enabled flag did not raise irq");

endmodule // usb_interrupt_enable_mask

/* usb_engine_model.sv */
`timescale 1ns/1ps
// ************************************************************
// usb engine stand-in: handshake and bus event pulses
// ************************************************************
module usb_engine_model (
    input  wire logic       pclk,
    output logic            hs_valid,
    output logic            hs_ack,
    output logic            hs_tx,
    output logic            hs_setup,
    output logic [2:0]      hs_ep,
    output logic [8:0]      bus_events
);
    // idle qualifiers parked on a pattern, so a stale value is never mistaken for a live one
    initial begin
        hs_valid   = 1'b0;
        hs_ack     = 1'b1;
        hs_tx      = 1'b1;
        hs_setup   = 1'b1;
        hs_ep      = 3'h5;
        bus_events = 9'h000;
    end

    // one-cycle pulse on a single bus event line
    task automatic bus_pulse(input int idx);
        @(posedge pclk);
        bus_events <= 9'h001 << idx;
        @(posedge pclk);
        bus_events <= 9'h000;
    endtask

    // one handshake; qualifiers are inverted once the pulse is over
    task automatic handshake(input logic [2:0] ep, input logic tx, input logic ack, input logic setup);
        @(posedge pclk);
        hs_valid <= 1'b1;
        hs_ack   <= ack;
        hs_tx    <= tx;
        hs_setup <= setup;
        hs_ep    <= ep;
        @(posedge pclk);
        hs_valid <= 1'b0;
        hs_ack   <= ~ack;
        hs_tx    <= ~tx;
        hs_setup <= ~setup;
        hs_ep    <= ~ep;
    endtask
endmodule // usb_engine_model

/* usb_interrupt_enable_mask_tb_top.sv */
`timescale 1ns/1ps
module usb_interrupt_enable_mask_tb_top;
    import usb_irq_pkg::*;
    // ************************************************************
    // signals and counters
    // ************************************************************
    logic                   pclk, presetn, psel, penable, pwrite;   // apb master side
    logic [ADDR_W-1:0]      paddr;                                  // byte address
    logic [31:0]            pwdata, prdata, rd, exp;                // data and scratch
    logic                   pready, pslverr, irq, err;              // answers
    logic                   hs_valid, hs_ack, hs_tx, hs_setup;      // engine handshake
    logic [EP_NUM_W-1:0]    hs_ep;                                  // endpoint number
    logic [BUS_EV_W-1:0]    bus_events;                             // bus event pulses
    int                     error_cnt, samples_checked, cyc, k, i;  // bookkeeping

    usb_interrupt_enable_mask dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .hs_valid(hs_valid), .hs_ack(hs_ack), .hs_tx(hs_tx), .hs_setup(hs_setup),
        .hs_ep(hs_ep), .bus_events(bus_events), .irq(irq));
    usb_engine_model eng_u (.pclk(pclk), .hs_valid(hs_valid), .hs_ack(hs_ack), .hs_tx(hs_tx),
        .hs_setup(hs_setup), .hs_ep(hs_ep), .bus_events(bus_events));

    // 25 MHz clock
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    // ************************************************************
    // shared tasks
    // ************************************************************
    task automatic complete_run();
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask

    // one apb transfer; request held until the rising edge that samples pready high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        int n;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            chk("pready wait", 32'h1, 32'h0);
            complete_run();
        end
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, rd, err);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input string nm);
        apb(1'b0, a, 32'h0, rd, err);
        chk(nm, e, rd);
        chk("slave error", 32'h0, {31'h0, err});
    endtask

    // irq settles within three edges of its cause
    task automatic irq_chk(input logic e);
        repeat (3) @(posedge pclk);
        @(negedge pclk);
        chk("irq level", {31'h0, e}, {31'h0, irq});
    endtask

    // expected status bit for one handshake, from the select fields of the mode word
    function automatic logic [31:0] hs_exp(input logic [2:0] ep, input logic tx, input logic ack,
                                           input logic setup, input logic [31:0] md);
        logic [1:0] s;
        int         b;
        s = (ep == 3'h0) ? md[2:1] : (tx ? md[4:3] : md[6:5]);
        b = 10 + 2 * int'(ep) + ((tx && !setup) ? 1 : 0);
        hs_exp = (ack ? s[0] : s[1]) ? (32'h0000_0001 << b) : 32'h0000_0000;
    endfunction

    // hang guard
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            complete_run();
        end
    end

    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        {psel, penable, pwrite, paddr, pwdata, presetn} = '0;
        {error_cnt, samples_checked, cyc} = '0;
        void'($urandom(32'h9068));
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        // reset values and refused accesses
        rd_chk(IE_OFS, IE_RESET, "enable reset");
        rd_chk(MODE_OFS, {25'h0, MODE_RESET}, "mode reset");
        rd_chk(STAT_OFS, 32'h0, "status reset");
        wr(STAT_OFS, 32'hFFFF_FFFF);
        rd_chk(STAT_OFS, 32'h0, "status read only");
        rd_chk(CLR_OFS, 32'h0, "clear reads zero");
        apb(1'b0, 8'h10, 32'h0, rd, err);
        chk("unmapped error", 32'h1, {31'h0, err});
        chk("unmapped data", 32'h0, rd);
        // enable readback, reserved bits read zero
        for (k = 0; k < 10; k++) begin
            exp = (k == 0) ? 32'hFFFF_FFFF : $urandom;
            wr(IE_OFS, exp);
            rd_chk(IE_OFS, exp & IE_VALID, "enable readback");
        end
        // every endpoint, direction and handshake kind, with random select values
        for (k = 0; k < 64; k++) begin
            exp = {25'h0, 6'($urandom), 1'b1};
            wr(MODE_OFS, exp);
            wr(IE_OFS, IE_VALID);
            wr(CLR_OFS, 32'hFFFF_FFFF);
            eng_u.handshake(k[2:0], k[3], k[4], k[5] & (k[2:0] == 3'h0) & ~k[3]);
            exp = hs_exp(k[2:0], k[3], k[4], k[5] & (k[2:0] == 3'h0) & ~k[3], exp);
            repeat (3) @(posedge pclk);
            rd_chk(STAT_OFS, exp, "handshake status");
            @(negedge pclk);
            chk("handshake irq", {31'h0, |exp}, {31'h0, irq});
        end
        // each bus event alone, then with every enable but its own
        for (i = 0; i < BUS_EV_W; i++) begin
            wr(MODE_OFS, 32'h0000_002B);
            wr(IE_OFS, 32'h0000_0001 << i);
            wr(CLR_OFS, 32'hFFFF_FFFF);
            eng_u.bus_pulse(i);
            irq_chk(1'b1);
            rd_chk(STAT_OFS, 32'h0000_0001 << i, "event status");
            wr(IE_OFS, IE_VALID & ~(32'h0000_0001 << i));
            irq_chk(1'b0);
        end
        // bus reset clears all enables but its own, mode is left alone
        wr(MODE_OFS, 32'h0000_0055);
        wr(IE_OFS, IE_VALID);
        eng_u.bus_pulse(BRST_BIT);
        rd_chk(IE_OFS, BRST_KEEP, "enable after bus reset");
        rd_chk(MODE_OFS, 32'h0000_0055, "mode after bus reset");
        wr(IE_OFS, IE_VALID & ~BRST_KEEP);
        eng_u.bus_pulse(BRST_BIT);
        rd_chk(IE_OFS, 32'h0, "enable after second bus reset");
        // global enable gates the suspend interrupt
        wr(MODE_OFS, 32'h0000_002A);
        wr(IE_OFS, IE_VALID);
        wr(CLR_OFS, 32'hFFFF_FFFF);
        eng_u.bus_pulse(SUSP_BIT);
        irq_chk(1'b0);
        wr(MODE_OFS, 32'h0000_002B);
        irq_chk(1'b1);
        wr(CLR_OFS, 32'h0000_0008);
        irq_chk(1'b0);
        // reset in mid-run brings the mask back to zero
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rd_chk(IE_OFS, IE_RESET, "enable after reset");
        rd_chk(MODE_OFS, {25'h0, MODE_RESET}, "mode after reset");
        complete_run();
    end
endmodule // usb_interrupt_enable_mask_tb_top
